// ### sac_top.sv
// storage address formation and checking for the central control unit
`timescale 1ns/1ps
module sac_top import sac_pkg::*; #(
    parameter logic [22:0] INSTALLED_BYTES = FULL_LIMIT,
    parameter bit REDUCED = 1'b0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // request from program levels and cycle-steal users
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_store_i,
    input wire logic req_write_i,
    input wire logic req_io_i,
    input wire logic req_io_dir_i,
    input wire logic [1:0] req_len_i,
    input wire logic [22:0] req_addr_i,
    input wire logic [23:0] req_wdata_i,
    input wire logic [23:0] reg_rdata_i,
    // configuration
    input wire logic prot_en_i,
    input wire logic hard_sel_i,
    input wire logic pres_wr_i,
    input wire logic [9:0] pres_blk_i,
    input wire logic pres_val_i,
    // main storage side
    output logic mem_valid_o,
    output logic mem_write_o,
    output logic [21:0] mem_addr_o,
    output logic [1:0] mem_len_o,
    // register side
    output logic reg_wr_o,
    output logic [23:0] reg_wdata_o,
    // answer
    output logic rsp_valid_o,
    output logic [23:0] rsp_rdata_o,
    output logic exc_irq_o,
    output logic exc_hard_o,
    output logic align_exc_o
);
    // reduced variant caps the installed size
    localparam logic [22:0] LIMIT = // see R12
        (REDUCED && INSTALLED_BYTES > REDUCED_LIMIT) ? REDUCED_LIMIT : INSTALLED_BYTES;

    sac_regs_t q, d;
    sac_pres_if pres ();
    logic take;
    logic [21:0] req_eff;
    logic out_of_range;
    logic bad_addr;
    logic misalign;

    sac_pres_mem #(.DEPTH(BLK_DEPTH)) u_pres (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .pres(pres)
    );

    // request handshake and presence lookup of the addressed block
    assign req_ready_o = (q.st == S_IDLE);
    assign take = req_valid_i && req_ready_o;
    assign req_eff = sac_wrap(req_addr_i); // see R8
    assign pres.wr_en = pres_wr_i;
    assign pres.wr_blk = pres_blk_i;
    assign pres.wr_val = pres_val_i;
    assign pres.rd_blk = req_eff[BLK_LSB +: BLK_W]; // see R13

    // checks on the captured address; top bit set is always past the limit
    assign out_of_range = ({1'b0, q.eff} >= LIMIT); // see R1, R2, R6
    assign bad_addr = out_of_range || !pres.rd_val || (q.wrapped && prot_en_i); // see R7, R8
    assign misalign = (q.len != LEN_ONE) && q.eff[0]; // see R9

    // next state
    always_comb begin
        d = q;
        d.mem_valid = 1'b0;
        d.reg_wr = 1'b0;
        d.rsp_valid = 1'b0;
        d.exc_irq = 1'b0;
        d.exc_hard = 1'b0;
        d.align_exc = 1'b0;
        case (q.st)
            S_IDLE: begin
                if (take) begin
                    d.st = S_LOOK;
                    d.eff = req_eff; // see R3
                    d.wrapped = (req_addr_i > WRAP_POINT);
                    d.store = req_store_i;
                    d.write = req_io_i ? req_io_dir_i : req_write_i; // see R11
                    d.len = req_len_i; // see R10
                    d.wdata = req_wdata_i;
                    d.rdata = {EXT_ZERO, reg_rdata_i[EXT_LSB-1:0]}; // see R5
                end
            end
            S_LOOK: begin
                d.st = S_IDLE;
                d.rsp_valid = 1'b1;
                if (q.store) begin
                    d.exc_irq = (bad_addr || misalign) && !hard_sel_i; // see R6
                    d.exc_hard = (bad_addr || misalign) && hard_sel_i;
                    d.align_exc = misalign;
                    d.mem_valid = !(bad_addr || misalign); // see R14
                    d.mem_write = q.write;
                    d.mem_addr = q.eff; // see R10
                    d.mem_len = q.len;
                end else begin
                    d.reg_wr = q.write;
                    d.reg_wdata = {EXT_ZERO, q.wdata[EXT_LSB-1:0]}; // see R4
                end
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign mem_valid_o = q.mem_valid;
    assign mem_write_o = q.mem_write;
    assign mem_addr_o = q.mem_addr;
    assign mem_len_o = q.mem_len;
    assign reg_wr_o = q.reg_wr;
    assign reg_wdata_o = q.reg_wdata;
    assign rsp_valid_o = q.rsp_valid;
    assign rsp_rdata_o = q.rdata;
    assign exc_irq_o = q.exc_irq;
    assign exc_hard_o = q.exc_hard;
    assign align_exc_o = q.align_exc;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    // every taken request is answered two edges later
    answer_timing_a: assert property (take |-> ##1 (!req_ready_o && !rsp_valid_o) // see R10
        ##1 rsp_valid_o)
        else $error("answer not two cycles after take");

    // an answer always frees the request port again
    ready_at_rsp_a: assert property (rsp_valid_o |-> req_ready_o) // see R10
        else $error("not ready when answering");

    // storage access, register write and exceptions only come with the answer
    pulse_with_rsp_a: assert property ((mem_valid_o || reg_wr_o || exc_irq_o || exc_hard_o)
        |-> rsp_valid_o) // see R10
        else $error("result pulse without answer");

    // a request goes either to storage or to a register, never both
    one_target_a: assert property (!(mem_valid_o && reg_wr_o)) // see R4
        else $error("storage and register hit together");

    // the group length reaches storage unchanged
    len_pass_a: assert property (mem_valid_o |-> mem_len_o == $past(req_len_i, 2)) // see R10
        else $error("group length changed");

    // a flagged access never reaches storage
    exc_no_access_a: assert property ((exc_irq_o || exc_hard_o) |-> !mem_valid_o) // see R14
        else $error("storage access with exception");

    // an exception is reported one way only
    one_report_a: assert property (!(exc_irq_o && exc_hard_o)) // see R6
        else $error("exception reported twice");

    // hard check selection keeps the level 1 interrupt quiet
    hard_select_a: assert property (take && req_store_i ##1 hard_sel_i |-> ##1 !exc_irq_o) // see R6
        else $error("interrupt despite hard check");

    // a misaligned group is always reported as an exception
    align_report_a: assert property (align_exc_o |-> (exc_irq_o || exc_hard_o)) // see R14
        else $error("alignment fault not reported");

    // register reads return a zero extension byte
    ext_read_zero_a: assert property (rsp_valid_o && !exc_irq_o |-> // see R5
        rsp_rdata_o[23:16] == 8'h00)
        else $error("extension byte not zero on read");

    // register writes drop the extension byte, keep the rest
    ext_write_drop_a: assert property (reg_wr_o |-> // see R4
        reg_wdata_o == {8'h00, $past(req_wdata_i[15:0], 2)})
        else $error("register write data wrong");

    // beyond installed size raises the exception
    beyond_size_a: assert property (take && req_store_i && // see R6
        {1'b0, req_eff} >= LIMIT |-> ##2 (exc_irq_o || exc_hard_o))
        else $error("no exception beyond installed size");

    // an absent block looked up for storage raises the exception
    absent_exc_a: assert property (take && req_store_i ##1 !pres.rd_val // see R13
        |-> ##1 (exc_irq_o || exc_hard_o))
        else $error("no exception on absent block");

    // wrapped address is the computed one minus the wrap point
    wrap_addr_a: assert property (mem_valid_o |-> // see R8
        mem_addr_o == sac_wrap($past(req_addr_i, 2)))
        else $error("storage address not wrapped");

    // wrapped access with protection on is flagged
    wrap_prot_a: assert property (take && req_store_i && prot_en_i && // see R8
        req_addr_i > WRAP_POINT ##1 prot_en_i |-> ##1 (exc_irq_o || exc_hard_o))
        else $error("no exception on wrap");

    // only present blocks are accessed
    absent_block_a: assert property (mem_valid_o |-> $past(pres.rd_val)) // see R7, R13
        else $error("access to absent block");

    // storage addresses keep the top bit zero
    msb_zero_a: assert property (mem_valid_o |-> !mem_addr_o[EXT_BIT2_POS]) // see R1, R2
        else $error("address top bit set");

    // adapter transfers take direction from the instruction bit
    io_dir_a: assert property (take && !req_store_i && req_io_i |-> // see R11
        ##2 (reg_wr_o == $past(req_io_dir_i, 2)))
        else $error("adapter direction wrong");

    // reduced variant never accepts past 512 KB
    reduced_cap_a: assert property (mem_valid_o && REDUCED |-> // see R12
        {1'b0, mem_addr_o} < REDUCED_LIMIT)
        else $error("reduced size exceeded");
endmodule

// ### sac_pkg.sv
// constants and types for the storage address check block
// How it works
// R1 - storage addresses are 22 bits and their top bit must be zero
// R2 - address registers are extension, middle and low bytes; extension bit 2 zero
// R3 - all three bytes belong to the register value, full 22 bits kept
// R4 - register writes not addressing storage ignore the extension byte
// R5 - register reads not addressing storage return a zero extension byte
// R6 - address below wrap point but beyond installed size raises address exception
// R7 - access into a block whose exception key is 0 raises address exception
// R8 - above 4194303 access address minus 4194303, exception if protection enabled
// R9 - software keeps instructions and half or full words on even addresses
// R10 - a byte group is addressed by its high-order byte, length given
// R11 - one instruction bit picks input or output for adapter transfers
// R12 - reduced variant limits the installed size check to 512 KB
// R13 - one presence bit per 4 KB block, absent block raises level 1 exception; with hard_sel_i set the code raises exc_hard_o instead
// R14 - an access that raises the exception never writes storage
package sac_pkg;
    localparam int ADDR_W = 22;
    localparam int CALC_W = 23;
    localparam int BLK_LSB = 12;
    localparam int BLK_W = 10;
    localparam int BLK_DEPTH = 1024;
    localparam int EXT_LSB = 16;
    localparam int EXT_BIT2_POS = 21;
    localparam logic [22:0] WRAP_POINT = 23'h3FFFFF;
    localparam logic [22:0] FULL_LIMIT = 23'h200000;
    localparam logic [22:0] REDUCED_LIMIT = 23'h080000;
    localparam logic [7:0] EXT_ZERO = 8'h00;
    localparam logic [1:0] LEN_ONE = 2'h0;

    typedef enum logic [0:0] {
        S_IDLE,
        S_LOOK
    } sac_state_t;

    typedef struct packed {
        sac_state_t st;
        logic [21:0] eff;
        logic wrapped;
        logic store;
        logic write;
        logic [1:0] len;
        logic [23:0] wdata;
        logic [23:0] rdata;
        logic mem_valid;
        logic mem_write;
        logic [21:0] mem_addr;
        logic [1:0] mem_len;
        logic reg_wr;
        logic [23:0] reg_wdata;
        logic rsp_valid;
        logic exc_irq;
        logic exc_hard;
        logic align_exc;
    } sac_regs_t;

    // wrap a computed address back into the 22-bit space
    function automatic logic [21:0] sac_wrap(input logic [22:0] a);
        logic [22:0] w;
        w = (a > WRAP_POINT) ? a - WRAP_POINT : a;
        return w[21:0];
    endfunction
endpackage

// ### sac_pres_if.sv
// carrier between the address checker and its block presence store
`timescale 1ns/1ps
interface sac_pres_if;
    logic wr_en;
    logic [9:0] wr_blk;
    logic wr_val;
    logic [9:0] rd_blk;
    logic rd_val;
    modport mgr (output wr_en, output wr_blk, output wr_val, output rd_blk, input rd_val);
    modport mem (input wr_en, input wr_blk, input wr_val, input rd_blk, output rd_val);
endinterface

// ### sac_pres_mem.sv
// one presence bit per 4 KB storage block, registered read
`timescale 1ns/1ps
module sac_pres_mem import sac_pkg::*; #(
    parameter int DEPTH = BLK_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // store port
    sac_pres_if.mem pres
);
    logic bits_q [DEPTH];
    logic rd_q;

    // presence bits are loaded by software before use, they have no reset
    always_ff @(posedge clk_i) begin
        if (pres.wr_en) begin
            bits_q[pres.wr_blk] <= pres.wr_val;
        end
    end

    // read data out of a flop, a new write shows on the next read
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= bits_q[pres.rd_blk];
        end
    end

    assign pres.rd_val = rd_q;
endmodule

// ### sac_store_model.sv
// behavioural main storage that counts writes and keeps the last group address
`timescale 1ns/1ps
module sac_store_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // access from the address checker
    input wire logic mem_valid_i,
    input wire logic mem_write_i,
    input wire logic [21:0] mem_addr_i,
    // observation for the bench
    output logic [7:0] wr_cnt_o,
    output logic [21:0] last_addr_o
);
    // only 22-bit addresses arrive; a group is known by its high-order byte
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            wr_cnt_o <= 8'h00;
            last_addr_o <= 22'h000000;
        end else if (mem_valid_i) begin
            last_addr_o <= mem_addr_i;
            wr_cnt_o <= wr_cnt_o + {7'h00, mem_write_i};
        end
    end
endmodule

// ### tb_top.sv
// self-checking bench for the storage address check block
`timescale 1ns/1ps
module tb_top;
    logic clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0, req_store_i = 1'b0;
    logic req_write_i = 1'b0, req_io_i = 1'b0, req_io_dir_i = 1'b0, prot_en_i = 1'b0;
    logic hard_sel_i = 1'b0, pres_wr_i = 1'b0, pres_val_i = 1'b0;
    logic [1:0] req_len_i = 2'h0;
    logic [22:0] req_addr_i = 23'h000000;
    logic [23:0] req_wdata_i = 24'h000000, reg_rdata_i = 24'h000000;
    logic [9:0] pres_blk_i = 10'h000;
    logic req_ready_o, mem_valid_o, mem_write_o, reg_wr_o, rsp_valid_o;
    logic exc_irq_o, exc_hard_o, align_exc_o;
    logic [21:0] mem_addr_o, last_addr;
    logic [1:0] mem_len_o;
    logic [23:0] reg_wdata_o, rsp_rdata_o;
    logic [7:0] wr_cnt;
    logic red_mv, red_exc, red_rv;
    int fails = 0, tests_run = 0;

    sac_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_store_i(req_store_i), .req_write_i(req_write_i),
        .req_io_i(req_io_i), .req_io_dir_i(req_io_dir_i), .req_len_i(req_len_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .reg_rdata_i(reg_rdata_i),
        .prot_en_i(prot_en_i), .hard_sel_i(hard_sel_i), .pres_wr_i(pres_wr_i),
        .pres_blk_i(pres_blk_i), .pres_val_i(pres_val_i), .mem_valid_o(mem_valid_o),
        .mem_write_o(mem_write_o), .mem_addr_o(mem_addr_o), .mem_len_o(mem_len_o),
        .reg_wr_o(reg_wr_o), .reg_wdata_o(reg_wdata_o), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .exc_irq_o(exc_irq_o), .exc_hard_o(exc_hard_o),
        .align_exc_o(align_exc_o));
    sac_store_model store (.clk_i(clk_i), .nrst_i(nrst_i), .mem_valid_i(mem_valid_o),
        .mem_write_i(mem_write_o), .mem_addr_i(mem_addr_o), .wr_cnt_o(wr_cnt),
        .last_addr_o(last_addr));
    // reduced variant sees the same requests
    sac_top #(.REDUCED(1'b1)) dut_red (.clk_i(clk_i), .nrst_i(nrst_i),
        .req_valid_i(req_valid_i), .req_ready_o(), .req_store_i(req_store_i),
        .req_write_i(req_write_i), .req_io_i(req_io_i), .req_io_dir_i(req_io_dir_i),
        .req_len_i(req_len_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
        .reg_rdata_i(reg_rdata_i), .prot_en_i(prot_en_i), .hard_sel_i(hard_sel_i),
        .pres_wr_i(pres_wr_i), .pres_blk_i(pres_blk_i), .pres_val_i(pres_val_i),
        .mem_valid_o(red_mv), .mem_write_o(), .mem_addr_o(), .mem_len_o(), .reg_wr_o(),
        .reg_wdata_o(), .rsp_valid_o(red_rv), .rsp_rdata_o(), .exc_irq_o(red_exc),
        .exc_hard_o(), .align_exc_o());

    // clock at 200 MHz
    always #2.5 clk_i = ~clk_i;

    task automatic chk(input string nm, input logic [23:0] s, input logic [23:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one request, returns at the falling edge where the answer stands
    task automatic req(input logic st, wr, io, dir, input logic [1:0] ln,
                       input logic [22:0] a, input logic [23:0] wd, rd);
        @(negedge clk_i);
        {req_store_i, req_write_i, req_io_i, req_io_dir_i} = {st, wr, io, dir};
        {req_len_i, req_addr_i, req_wdata_i, reg_rdata_i} = {ln, a, wd, rd};
        req_valid_i = 1'b1;
        @(negedge clk_i);
        req_valid_i = 1'b0;
        @(negedge clk_i);
    endtask

    task automatic outc(input logic mv, input logic ex, input logic al);
        chk("rsp_valid", 24'(rsp_valid_o), 24'h000001);
        chk("mem_valid", 24'(mem_valid_o), 24'(mv));
        chk("exception", 24'(exc_irq_o | exc_hard_o), 24'(ex));
        chk("align", 24'(align_exc_o), 24'(al));
    endtask

    task automatic pres(input logic [9:0] b, input logic v);
        @(negedge clk_i);
        {pres_wr_i, pres_blk_i, pres_val_i} = {1'b1, b, v};
        @(negedge clk_i);
        pres_wr_i = 1'b0;
    endtask

    task automatic t_store();
        req(1, 1, 0, 0, 2'h1, 23'h001004, 24'h0, 24'h0);
        outc(1'b1, 1'b0, 1'b0);
        chk("mem_addr", 24'(mem_addr_o), 24'h001004);
        chk("mem_len", 24'(mem_len_o), 24'h000001);
        req(1, 0, 0, 0, 2'h0, 23'h1FFFFF, 24'h0, 24'h0);
        outc(1'b1, 1'b0, 1'b0);
        chk("mem_addr", 24'(mem_addr_o), 24'h1FFFFF);
        chk("mem_write", 24'(mem_write_o), 24'h000000);
    endtask

    task automatic t_limit();
        req(1, 0, 0, 0, 2'h0, 23'h200000, 24'h0, 24'h0);
        outc(1'b0, 1'b1, 1'b0);
        req(1, 1, 0, 0, 2'h0, 23'h3F0000, 24'h0, 24'h0);
        outc(1'b0, 1'b1, 1'b0);
        hard_sel_i = 1'b1;
        req(1, 0, 0, 0, 2'h0, 23'h002000, 24'h0, 24'h0);
        chk("exc_hard", 24'(exc_hard_o), 24'h000001);
        chk("exc_irq", 24'(exc_irq_o), 24'h000000);
        hard_sel_i = 1'b0;
    endtask

    task automatic t_wrap();
        req(1, 0, 0, 0, 2'h0, 23'h400001, 24'h0, 24'h0);
        outc(1'b1, 1'b0, 1'b0);
        chk("wrap_addr", 24'(mem_addr_o), 24'h000002);
        prot_en_i = 1'b1;
        req(1, 0, 0, 0, 2'h0, 23'h400001, 24'h0, 24'h0);
        outc(1'b0, 1'b1, 1'b0);
        prot_en_i = 1'b0;
    endtask

    task automatic t_align();
        logic [7:0] n;
        n = wr_cnt;
        req(1, 1, 0, 0, 2'h1, 23'h001002, 24'h0, 24'h0);
        req(1, 1, 0, 0, 2'h1, 23'h001001, 24'h0, 24'h0);
        outc(1'b0, 1'b1, 1'b1);
        @(negedge clk_i);
        chk("writes", 24'(wr_cnt), 24'(n + 8'h01));
        chk("last_addr", 24'(last_addr), 24'h001002);
    endtask

    task automatic t_reg();
        req(0, 1, 0, 0, 2'h0, 23'h3F0000, 24'hFF1234, 24'h0);
        chk("reg_wr", 24'(reg_wr_o), 24'h000001);
        chk("reg_wdata", reg_wdata_o, 24'h001234);
        req(0, 0, 0, 0, 2'h0, 23'h000000, 24'h0, 24'hAB5678);
        chk("rsp_rdata", rsp_rdata_o, 24'h005678);
        req(0, 0, 1, 1, 2'h0, 23'h000000, 24'hC0BEEF, 24'h0);
        chk("io_out", 24'(reg_wr_o), 24'h000001);
        req(0, 1, 1, 0, 2'h0, 23'h000000, 24'h0, 24'h7E4321);
        chk("io_in", 24'(reg_wr_o), 24'h000000);
        chk("io_rdata", rsp_rdata_o, 24'h004321);
    endtask

    // reduced variant refuses what full storage still accepts
    task automatic t_reduced();
        pres(10'h07F, 1'b1);
        pres(10'h080, 1'b1);
        req(1, 0, 0, 0, 2'h0, 23'h07FFFE, 24'h0, 24'h0);
        chk("red_low", 24'(red_mv), 24'h000001);
        req(1, 0, 0, 0, 2'h0, 23'h080000, 24'h0, 24'h0);
        chk("full_access", 24'(mem_valid_o), 24'h000001);
        chk("red_rsp", 24'(red_rv), 24'h000001);
        chk("red_exc", 24'(red_exc), 24'h000001);
        chk("red_access", 24'(red_mv), 24'h000000);
    endtask

    // watchdog cuts a hang short
    initial begin
        #20000;
        fails++;
        report_and_stop();
    end

    // reset, presence map, then the scenarios
    initial begin
        repeat (3) @(negedge clk_i);
        nrst_i = 1'b1;
        @(negedge clk_i);
        chk("ready", 24'(req_ready_o), 24'h000001);
        pres(10'h000, 1'b1);
        pres(10'h001, 1'b1);
        pres(10'h1FF, 1'b1);
        pres(10'h002, 1'b0);
        t_store();
        t_limit();
        t_wrap();
        t_align();
        t_reg();
        t_reduced();
        report_and_stop();
    end
endmodule
